// >>> inc/ers_pkg.sv
// Package for the error record status bank.
// Shared by the core module and the verification side.
package ers_pkg;

   // Register map (byte addresses, 64-bit registers as two words)
   localparam logic [15:0] STATUS_BASE     = 16'h0010;
   localparam logic [15:0] RECORD_STRIDE   = 16'h0040;
   localparam logic [15:0] GSR_OFF_SMALL   = 16'h0E00;
   localparam logic [15:0] GSR_OFF_LARGE   = 16'hE000;
   localparam int          TBU_LARGE_LIMIT = 54;
   localparam logic [15:0] IDLE_OFF_SMALL  = 16'h0EB0;
   localparam logic [15:0] IDLE_OFF_LARGE  = 16'hE0B0;

   // Status field positions
   localparam int BLK_LSB  = 32;
   localparam int V_BIT    = 30;
   localparam int UE_BIT   = 29;
   localparam int OF_BIT   = 27;
   localparam int CE_HI    = 25;
   localparam int CE_LO    = 24;
   localparam int UET_LSB  = 20;
   localparam int MID_LSB  = 8;

   // Encodings
   localparam logic [7:0] MID_PING_TIMEOUT = 8'h0C;
   localparam logic [1:0] CE_SET           = 2'h2;
   localparam logic [1:0] UET_UE           = 2'h3;
   localparam logic [7:0] ARCHITECTED_ERROR_CODE_VALID       = 8'h01;

   // Reset values
   localparam logic [7:0] MID_RESET = 8'h00;
   localparam logic [7:0] BLK_RESET = 8'h00;

   // AXI4-Lite responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Error report from a fault check unit
   typedef struct packed {
      logic       valid;
      logic [7:0] record;
      logic [7:0] mech_id;
      logic       injected;
      logic [7:0] block_id;
   } ers_report_t;

endpackage

// >>> core/ers_status_bank.sv
// Error record status bank with AXI4-Lite register access.
// Assumes reporters hold a report for one cycle; single clock ref_clk.
`timescale 1ns/1ps

module ers_status_bank #(
   parameter int NUM_RECORDS = 4,
   parameter int NUM_TBUS    = 4
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   // Uncorrectable and correctable report paths
   input  wire ers_pkg::ers_report_t ue_report,
   input  wire ers_pkg::ers_report_t ce_report,
   // AXI4-Lite write address
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [15:0]         s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // AXI4-Lite write response
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output logic [1:0]               s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   input  wire logic [15:0]         s_axi_araddr,
   // AXI4-Lite read data
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   // Summary of valid records
   output logic [63:0]              record_group_summary
);

   ////////////////////////////////////////////////////////////////////////
   // Address map
   localparam logic [15:0] GSR_OFF = (NUM_TBUS < ers_pkg::TBU_LARGE_LIMIT)
      ? ers_pkg::GSR_OFF_SMALL : ers_pkg::GSR_OFF_LARGE;
   localparam logic [15:0] IDLE_OFF =
      (NUM_TBUS < ers_pkg::TBU_LARGE_LIMIT)
      ? ers_pkg::IDLE_OFF_SMALL : ers_pkg::IDLE_OFF_LARGE;

   ////////////////////////////////////////////////////////////////////////
   // Record state
   logic [NUM_RECORDS-1:0] v_reg;
   logic [NUM_RECORDS-1:0] ue_reg;
   logic [NUM_RECORDS-1:0] ce_reg;
   logic [NUM_RECORDS-1:0] of_reg;
   logic [7:0]             mid_reg [NUM_RECORDS];
   logic [7:0]             blk_reg;
   logic [63:0]            status  [NUM_RECORDS];

   // Write channel state
   logic        aw_hold_reg;
   logic [15:0] aw_addr_reg;
   logic        w_hold_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_go;
   logic        clr_pend_reg;
   logic        idle_reg;

   ////////////////////////////////////////////////////////////////////////
   // Write path: address and data taken in either order
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
   assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 16'h0000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_hold_reg <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         w_hold_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_hold_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_go)
         w_hold_reg <= 1'b0;
   end

   // Write decode: low word of a status register
   logic                   wr_hit;
   logic [NUM_RECORDS-1:0] wr_sel;
   always_comb
   begin
      wr_hit = 1'b0;
      wr_sel = '0;
      for (int i = 0; i < NUM_RECORDS; i++)
      begin
         if (aw_addr_reg == 16'(ers_pkg::STATUS_BASE
                                + 16'(i) * ers_pkg::RECORD_STRIDE))
         begin
            wr_sel[i] = wr_go;
            wr_hit    = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ers_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? ers_pkg::RESP_OKAY
                                : ers_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Idle flag drops for one cycle after a status write
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         clr_pend_reg <= 1'b0;
         idle_reg     <= 1'b1;
      end
      else
      begin
         clr_pend_reg <= |wr_sel;
         idle_reg     <= !(|wr_sel);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-record flag logic
   genvar g;
   generate
      for (g = 0; g < NUM_RECORDS; g++)
      begin : gen_rec
         logic ue_hit;
         logic ce_hit;
         logic clr_ok;
         logic wv;
         logic wue;
         logic wce;
         logic wof;
         // Separate paths: a correctable report never stalls an
         // uncorrectable one in the same cycle
         assign ue_hit = ue_report.valid
                      && ue_report.record == 8'(g);
         assign ce_hit = ce_report.valid
                      && ce_report.record == 8'(g);
         // Flags that the write leaves set; CE low bit ignored
         assign wv  = v_reg[g]  && !w_data_reg[ers_pkg::V_BIT];
         assign wue = ue_reg[g] && !w_data_reg[ers_pkg::UE_BIT];
         assign wof = of_reg[g] && !w_data_reg[ers_pkg::OF_BIT];
         assign wce = ce_reg[g] && !w_data_reg[ers_pkg::CE_HI];
         assign clr_ok = wr_sel[g] && w_strb_reg[3]
                      && !(wv || wue || wof || wce);

         always_ff @(posedge ref_clk)
         begin
            if (!resetn)
            begin
               v_reg[g]  <= 1'b0;
               ue_reg[g] <= 1'b0;
               ce_reg[g] <= 1'b0;
               of_reg[g] <= 1'b0;
            end
            else
            begin
               // New reports win over a clear in the same cycle
               v_reg[g]  <= ue_hit || ce_hit
                         || (v_reg[g] && !clr_ok);
               ue_reg[g] <= ue_hit
                         || (ue_reg[g] && !clr_ok);
               ce_reg[g] <= ce_hit
                         || (ce_reg[g] && !clr_ok);
               // A report soon after a clear still sees old flags
               of_reg[g] <= (ue_hit && (ue_reg[g] || clr_pend_reg))
                         || (ce_hit && (ce_reg[g] || clr_pend_reg))
                         || (of_reg[g] && !clr_ok);
            end
         end

         always_ff @(posedge ref_clk)
         begin
            if (!resetn)
               mid_reg[g] <= ers_pkg::MID_RESET;
            else if (ue_hit)
               mid_reg[g] <= ue_report.mech_id;
            else if (ce_hit && !ue_reg[g])
               mid_reg[g] <= ce_report.mech_id;
         end

         always_comb
         begin
            status[g] = 64'h0;
            status[g][ers_pkg::V_BIT]  = v_reg[g];
            status[g][ers_pkg::UE_BIT] = ue_reg[g];
            status[g][ers_pkg::OF_BIT] = of_reg[g];
            status[g][ers_pkg::CE_HI:ers_pkg::CE_LO] =
               ce_reg[g] ? ers_pkg::CE_SET : 2'h0;
            status[g][ers_pkg::UET_LSB+:2] =
               (v_reg[g] && ue_reg[g]) ? ers_pkg::UET_UE : 2'h0;
            status[g][ers_pkg::MID_LSB+:8] = mid_reg[g];
            status[g][7:0] =
               v_reg[g] ? ers_pkg::ARCHITECTED_ERROR_CODE_VALID : 8'h00;
            if (g == 0)
               status[g][ers_pkg::BLK_LSB+:8] = blk_reg;
         end

         // Summary clears only after the write lands
         assign record_group_summary[g] = v_reg[g];
      end
   endgenerate

   if (NUM_RECORDS < 64)
   begin : gen_pad
      assign record_group_summary[63:NUM_RECORDS] = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Remote block id on record 0
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         blk_reg <= ers_pkg::BLK_RESET;
      else if (ue_report.valid && ue_report.record == 8'h00
               && ue_report.mech_id == ers_pkg::MID_PING_TIMEOUT
               && !ue_report.injected)
         blk_reg <= ue_report.block_id;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path
   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb
   begin
      rd_word = 32'h00000000;
      rd_hit  = 1'b0;
      if (s_axi_araddr == GSR_OFF)
      begin
         rd_word = record_group_summary[31:0];
         rd_hit  = 1'b1;
      end
      else if (s_axi_araddr == 16'(GSR_OFF + 16'h0004))
      begin
         rd_word = record_group_summary[63:32];
         rd_hit  = 1'b1;
      end
      else if (s_axi_araddr == IDLE_OFF)
      begin
         rd_word = {31'h0, idle_reg};
         rd_hit  = 1'b1;
      end
      for (int i = 0; i < NUM_RECORDS; i++)
      begin
         if (s_axi_araddr == 16'(ers_pkg::STATUS_BASE
                                 + 16'(i) * ers_pkg::RECORD_STRIDE))
         begin
            rd_word = status[i][31:0];
            rd_hit  = 1'b1;
         end
         else if (s_axi_araddr == 16'(ers_pkg::STATUS_BASE + 16'h0004
                                 + 16'(i) * ers_pkg::RECORD_STRIDE))
         begin
            rd_word = status[i][63:32];
            rd_hit  = 1'b1;
         end
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= ers_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? ers_pkg::RESP_OKAY
                                : ers_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule

// >>> test/ers_status_bank_checker.sv
// Port checker for the error record status bank.
// Bound to ers_status_bank below; one clock, synchronous low reset.
`timescale 1ns/1ps
module ers_status_bank_checker #(
   parameter int NUM_RECORDS = 4
) (
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 resetn,
   // Report paths
   input wire ers_pkg::ers_report_t ue_report,
   input wire ers_pkg::ers_report_t ce_report,
   // Bus handshakes
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_rvalid,
   // Summary
   input wire logic [63:0]          record_group_summary
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   AST_UE_SUM:
      assert property (ue_report.valid && ue_report.record < NUM_RECORDS
         |=> record_group_summary[$past(ue_report.record)])
      else $error("summary bit missing after uncorrectable report");
   AST_CE_SUM:
      assert property (ce_report.valid && ce_report.record < NUM_RECORDS
         |=> record_group_summary[$past(ce_report.record)])
      else $error("summary bit missing after correctable report");
   AST_SUM_UNUSED:
      assert property ((record_group_summary >> NUM_RECORDS) == 64'h0)
      else $error("summary bit set for a missing record");
   AST_SUM_RISE:
      assert property (|(record_group_summary & ~$past(record_group_summary))
         |-> $past(ue_report.valid || ce_report.valid))
      else $error("summary bit rose with no report");
   AST_SUM_FALL:
      assert property (|(~record_group_summary & $past(record_group_summary))
         |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("summary bit fell with no write");
   AST_READ_ANS:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // Both halves are held one cycle before the response registers
   AST_WRITE_ANS:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
         && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   AST_WRITE_HOLD:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_READ_HOLD:
      assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");
endmodule

bind ers_status_bank ers_status_bank_checker #(.NUM_RECORDS(NUM_RECORDS)) chk (
   .ref_clk, .resetn, .ue_report, .ce_report, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .record_group_summary
);

// >>> test/ers_reporter_model.sv
// Model of the fault check units feeding the two report paths.
// Driven by the bench through its pulse task.
`timescale 1ns/1ps
module ers_reporter_model (
   // Clock
   input wire logic           ref_clk,
   // Report paths
   output ers_pkg::ers_report_t ue_report,
   output ers_pkg::ers_report_t ce_report
);
   initial
   begin
      ue_report = '0;
      ce_report = '0;
   end
   // One-cycle pulse per path; idle payload inverted so stale data shows
   task automatic pulse(input ers_pkg::ers_report_t u,
                        input ers_pkg::ers_report_t c);
      @(posedge ref_clk);
      ue_report <= u;
      ce_report <= c;
      @(posedge ref_clk);
      ue_report <= ers_pkg::ers_report_t'({1'b0, ~u[24:0]});
      ce_report <= ers_pkg::ers_report_t'({1'b0, ~c[24:0]});
   endtask
endmodule

// >>> test/ers_status_bank_test.sv
// Self-checking bench for the error record status bank.
// Bus driven here; reports come from ers_reporter_model.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("ERROR %s expected %h seen %h", nm, e, g); \
      end \
   end
module ers_status_bank_test;
   logic ref_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [63:0] record_group_summary;
   ers_pkg::ers_report_t ue_report, ce_report;
   int          mismatches = 0;
   int          n_compared = 0;
   localparam ers_pkg::ers_report_t nr = '0;

   ers_reporter_model mdl (.ref_clk, .ue_report, .ce_report);
   ers_status_bank dut (
      .ref_clk, .resetn, .ue_report, .ce_report, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .record_group_summary
   );
   always #20 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
         begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
         begin
            rdat = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   function automatic logic [15:0] sa(input int r);
      return ers_pkg::STATUS_BASE + 16'(r) * ers_pkg::RECORD_STRIDE;
   endfunction
   function automatic ers_pkg::ers_report_t rp(logic [7:0] r, logic [7:0] m,
                                               logic i, logic [7:0] b);
      return '{1'b1, r, m, i, b};
   endfunction
   // Status write, then wait for idle before the next report
   task automatic wst(input int r, input logic [31:0] d);
      wr(sa(r), d);
      repeat (8)
      begin
         rd(ers_pkg::IDLE_OFF_SMALL);
         if (rdat[0] === 1'b1) break;
      end
      `CHK("idle", 1'b1, rdat[0])
   endtask
   task automatic chk_st(input int r, input logic v, ue, of,
                         input logic [1:0] ce, input logic [7:0] m);
      logic [31:0] e, k;
      e = {1'b0, v, ue, 1'b0, of, 1'b0, ce, 2'h0, {2{ue}}, 4'h0, m, 7'h0, v};
      k = !v ? 32'h0000_00FF : ue ? 32'hFFFF_FFFF : 32'hFFCF_FFFF;
      rd(sa(r));
      `CHK("status", e & k, rdat & k)
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd(ers_pkg::GSR_OFF_SMALL);
      `CHK("summary", 32'h0, rdat)
      chk_st(0, 0, 0, 0, 2'h0, 8'h00);
   endtask
   task automatic t_ce_ue;
      mdl.pulse(nr, rp(8'h01, 8'h05, 1'b0, 8'h00));
      chk_st(1, 1, 0, 0, 2'h2, 8'h05);
      mdl.pulse(rp(8'h01, 8'h07, 1'b0, 8'h00), nr);
      chk_st(1, 1, 1, 0, 2'h2, 8'h07);
      rd(ers_pkg::GSR_OFF_SMALL);
      `CHK("summary", 32'h2, rdat)
      mdl.pulse(rp(8'h01, 8'h07, 1'b0, 8'h00), nr);
      chk_st(1, 1, 1, 1, 2'h2, 8'h07);
      wst(1, 32'h4000_0000);
      chk_st(1, 1, 1, 1, 2'h2, 8'h07);
      wst(1, 32'h6B00_0000);
      chk_st(1, 0, 0, 0, 2'h0, 8'h00);
      rd(ers_pkg::GSR_OFF_SMALL);
      `CHK("summary", 32'h0, rdat)
   endtask
   task automatic t_ce_of;
      mdl.pulse(nr, rp(8'h02, 8'h03, 1'b0, 8'h00));
      mdl.pulse(nr, rp(8'h02, 8'h03, 1'b0, 8'h00));
      chk_st(2, 1, 0, 1, 2'h2, 8'h03);
      wst(2, 32'h4900_0000);
      chk_st(2, 1, 0, 1, 2'h2, 8'h03);
      wst(2, 32'h4A00_0000);
      chk_st(2, 0, 0, 0, 2'h0, 8'h00);
   endtask
   task automatic t_ping;
      mdl.pulse(rp(8'h00, ers_pkg::MID_PING_TIMEOUT, 1'b0, 8'h5A), nr);
      rd(sa(0) + 16'h0004);
      `CHK("block id", 32'h0000_005A, rdat)
      wst(0, 32'h6000_0000);
      // Injected timeout must leave the captured id alone
      mdl.pulse(rp(8'h00, ers_pkg::MID_PING_TIMEOUT, 1'b1, 8'h33), nr);
      rd(sa(0) + 16'h0004);
      `CHK("block id", 32'h0000_005A, rdat)
      wst(0, 32'h6000_0000);
   endtask
   task automatic t_both;
      mdl.pulse(rp(8'h03, 8'h11, 1'b0, 8'h00), rp(8'h03, 8'h11, 1'b0, 8'h00));
      chk_st(3, 1, 1, 0, 2'h2, 8'h11);
      rd(ers_pkg::GSR_OFF_SMALL + 16'h0004);
      `CHK("summary high", 32'h0, rdat)
   endtask
   task automatic t_bus;
      rd(16'h0004);
      `CHK("unmapped rresp", ers_pkg::RESP_SLVERR, rs)
      rd(ers_pkg::GSR_OFF_LARGE);
      `CHK("large summary rresp", ers_pkg::RESP_SLVERR, rs)
      wr(sa(0) + 16'h0004, 32'hFFFF_FFFF);
      `CHK("high write bresp", ers_pkg::RESP_SLVERR, rs)
   endtask
   task automatic stop_test;
      if (mismatches == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = 16'h0000;
      s_axi_araddr = 16'h0000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      t_reset();
      t_ce_ue();
      t_ce_of();
      t_ping();
      t_both();
      t_bus();
      stop_test();
   end
   // Run needs under two hundred cycles; twenty times that means a hang
   initial
   begin
      repeat (4000) @(posedge ref_clk);
      mismatches++;
      stop_test();
   end
endmodule
